// ---- port_cfg_if.sv ----
interface port_cfg_if;
  logic [3:0] base_sel;
  logic enable;
  logic auto_dir;
  logic line_std;
  modport src (output base_sel, output enable, output auto_dir, output line_std);
  modport sink (input base_sel, input enable, input auto_dir, input line_std);
endinterface : port_cfg_if

// ---- port_cfg_pkg.sv ----
package port_cfg_pkg;

  // register addresses on the configuration port
  localparam logic [7:0] OFF_FIRST_CTRL = 8'h00;
  localparam logic [7:0] OFF_SECOND_CTRL = 8'h01;
  localparam logic [7:0] OFF_DIR_MODE = 8'h02;
  localparam logic [7:0] OFF_XCVR_MODE = 8'h03;

  // port control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int BASE_W = 4;

  // direction mode register fields
  localparam int MODE_OE_FIRST = 0;
  localparam int MODE_OE_SECOND = 1;
  localparam int MODE_AUTO_FIRST = 4;
  localparam int MODE_AUTO_SECOND = 5;

  // transceiver mode register fields
  localparam int XCVR_FIRST = 0;
  localparam int XCVR_SECOND = 1;

  // reset values
  localparam logic [BASE_W-1:0] FIRST_BASE_RST = 4'h0;
  localparam logic [BASE_W-1:0] SECOND_BASE_RST = 4'h1;
  localparam logic EN_RST = 1'b1;
  localparam logic AUTO_RST = 1'b0;
  localparam logic OE_RST = 1'b1;
  localparam logic XCVR_RST = 1'b0;

  // host decode
  localparam int IO_ADDR_W = 16;
  localparam int PORT_SPAN_BITS = 3;
  localparam logic [BASE_W-1:0] CODE_LAST = 4'h9;

  function automatic logic code_ok(input logic [BASE_W-1:0] sel);
    code_ok = (sel <= CODE_LAST);
  endfunction : code_ok

  function automatic logic [IO_ADDR_W-1:0] base_of(input logic [BASE_W-1:0] sel);
    unique case (sel)
      4'h0: base_of = 16'h03F8;
      4'h1: base_of = 16'h02F8;
      4'h2: base_of = 16'h03E8;
      4'h3: base_of = 16'h02E8;
      4'h4: base_of = 16'h0200;
      4'h5: base_of = 16'h0208;
      4'h6: base_of = 16'h0220;
      4'h7: base_of = 16'h0228;
      4'h8: base_of = 16'h0238;
      4'h9: base_of = 16'h0338;
      // reserved codes never decode, see code_ok
      default: base_of = 16'h0000;
    endcase
  endfunction : base_of

endpackage : port_cfg_pkg

// ---- port_line_ctrl.sv ----
module port_line_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  port_cfg_if.sink cfg,
  // host io cycle
  input wire logic io_valid,
  input wire logic [port_cfg_pkg::IO_ADDR_W-1:0] io_addr,
  // from the port's serial engine
  input wire logic tx_pending,
  input wire logic rts_bit,
  input wire logic uart_tx,
  input wire logic uart_rts,
  // decode and line side
  output logic claim_q,
  output logic tx_q,
  output logic tx_oe_n_q,
  output logic rts_q,
  output logic rts_oe_n_q
);
  import port_cfg_pkg::*;

  logic claim_d;
  logic tx_d;
  logic tx_oe_n_d;
  logic rts_d;
  logic rts_oe_n_d;
  logic tx_drive;
  logic [IO_ADDR_W-1:0] base;

  always_comb begin
    base = base_of(cfg.base_sel);
    // eight-byte window at the selected base, reserved codes never match
    claim_d = io_valid && cfg.enable && code_ok(cfg.base_sel) &&
              (io_addr[IO_ADDR_W-1:PORT_SPAN_BITS] == base[IO_ADDR_W-1:PORT_SPAN_BITS]);
    if (!cfg.enable) begin
      tx_drive = 1'b0;
    end else if (!cfg.line_std) begin
      tx_drive = 1'b1;
    end else if (cfg.auto_dir) begin
      tx_drive = tx_pending;
    end else begin
      // manual direction: rts low turns the driver on
      tx_drive = !rts_bit;
    end
    tx_d = uart_tx;
    tx_oe_n_d = !tx_drive;
    rts_d = uart_rts;
    rts_oe_n_d = !cfg.enable;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      claim_q <= 1'b0;
      tx_q <= 1'b1;
      tx_oe_n_q <= 1'b1;
      rts_q <= 1'b1;
      rts_oe_n_q <= 1'b1;
    end else begin
      claim_q <= claim_d;
      tx_q <= tx_d;
      tx_oe_n_q <= tx_oe_n_d;
      rts_q <= rts_d;
      rts_oe_n_q <= rts_oe_n_d;
    end
  end

endmodule : port_line_ctrl

// ---- serial_engine_model.sv ----
module serial_engine_model (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic [1:0] send_req,
  input wire logic [1:0] rts_req,
  // to the block
  output logic [1:0] tx_pending,
  output logic [1:0] rts_bit,
  output logic [1:0] uart_tx,
  output logic [1:0] uart_rts
);
  timeunit 1ns;
  timeprecision 1ps;
  initial uart_tx = 2'h1;
  // toggling data so a stuck path shows
  always @(posedge clk) uart_tx <= #1 ~uart_tx;
  assign tx_pending = send_req;
  assign rts_bit = rts_req;
  assign uart_rts = ~rts_req;
endmodule : serial_engine_model

// ---- serial_port_config_direction_ctrl.sv ----
// Contract
// - base select codes 0..9 map to ten fixed io bases; 10..15 reserved
// - reset base select: first port 0 (3F8h), second port 1 (2F8h)
// - control bit 7 enables the port, read/write, resets to 1
// - control bits 6..4 ignore writes and read zero
// - rs-485 auto direction: driver on while bytes wait, off otherwise
// - rs-485 without auto direction: driver follows the rts bit
// - manual mode: rts 0 drives, rts 1 tri-states the transmitter
// - mode bit 5 auto direction second port, bit 4 first, reset 0
// - mode bits 1,0 output enables; 0 disables outputs, forwards io
// - mode bits 7..6 and 3..2 ignore writes and read zero
// - all four registers return to defaults on platform reset
// - transceiver bit 0 first, 1 second: 0 rs-232, 1 rs-422/485
// - disabled port's io range is not decoded
module serial_port_config_direction_ctrl #(
  parameter int NUM_PORTS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration register port
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata_q,
  output logic cfg_rvalid_q,
  // host io cycles
  input wire logic io_valid,
  input wire logic [port_cfg_pkg::IO_ADDR_W-1:0] io_addr,
  output logic [NUM_PORTS-1:0] io_claim_q,
  output logic io_forward_q,
  // serial engines
  input wire logic [NUM_PORTS-1:0] tx_pending,
  input wire logic [NUM_PORTS-1:0] rts_bit,
  input wire logic [NUM_PORTS-1:0] uart_tx,
  input wire logic [NUM_PORTS-1:0] uart_rts,
  // line transceivers
  output logic [NUM_PORTS-1:0] line_tx_q,
  output logic [NUM_PORTS-1:0] line_tx_oe_n_q,
  output logic [NUM_PORTS-1:0] line_rts_q,
  output logic [NUM_PORTS-1:0] line_rts_oe_n_q
);
  import port_cfg_pkg::*;

  // register state
  logic [1:0] en_q;
  logic [1:0] en_d;
  logic [1:0][BASE_W-1:0] base_q;
  logic [1:0][BASE_W-1:0] base_d;
  logic [1:0] auto_q;
  logic [1:0] auto_d;
  logic [1:0] oe_q;
  logic [1:0] oe_d;
  logic [1:0] xcvr_q;
  logic [1:0] xcvr_d;
  logic [7:0] rdata_d;
  logic rvalid_d;
  logic forward_d;
  logic [NUM_PORTS-1:0] claim;

  function automatic logic [7:0] ctrl_byte(input logic en, input logic [BASE_W-1:0] sel);
    ctrl_byte = {en, 3'h0, sel};
  endfunction : ctrl_byte

  // eight-byte window at the selected base; reserved codes never hit
  function automatic logic port_hit(input logic [IO_ADDR_W-1:0] addr, input logic [BASE_W-1:0] sel);
    logic [IO_ADDR_W-1:0] base;
    base = base_of(sel);
    port_hit = code_ok(sel) && (addr[IO_ADDR_W-1:PORT_SPAN_BITS] == base[IO_ADDR_W-1:PORT_SPAN_BITS]);
  endfunction : port_hit

  // register writes; reserved bits have no storage
  always_comb begin
    en_d = en_q;
    base_d = base_q;
    auto_d = auto_q;
    oe_d = oe_q;
    xcvr_d = xcvr_q;
    if (cfg_wr) begin
      unique case (cfg_addr)
        OFF_FIRST_CTRL: begin
          en_d[0] = cfg_wdata[CTRL_EN_BIT];
          base_d[0] = cfg_wdata[BASE_W-1:0];
        end
        OFF_SECOND_CTRL: begin
          en_d[1] = cfg_wdata[CTRL_EN_BIT];
          base_d[1] = cfg_wdata[BASE_W-1:0];
        end
        OFF_DIR_MODE: begin
          // no check against the transceiver bit: pairing them is software's duty
          auto_d[0] = cfg_wdata[MODE_AUTO_FIRST];
          auto_d[1] = cfg_wdata[MODE_AUTO_SECOND];
          oe_d[0] = cfg_wdata[MODE_OE_FIRST];
          oe_d[1] = cfg_wdata[MODE_OE_SECOND];
        end
        OFF_XCVR_MODE: begin
          xcvr_d[0] = cfg_wdata[XCVR_FIRST];
          xcvr_d[1] = cfg_wdata[XCVR_SECOND];
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
  end

  // register reads, one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    rvalid_d = cfg_rd;
    if (cfg_rd) begin
      unique case (cfg_addr)
        OFF_FIRST_CTRL: rdata_d = ctrl_byte(en_q[0], base_q[0]);
        OFF_SECOND_CTRL: rdata_d = ctrl_byte(en_q[1], base_q[1]);
        OFF_DIR_MODE: begin
          rdata_d[MODE_AUTO_FIRST] = auto_q[0];
          rdata_d[MODE_AUTO_SECOND] = auto_q[1];
          rdata_d[MODE_OE_FIRST] = oe_q[0];
          rdata_d[MODE_OE_SECOND] = oe_q[1];
        end
        OFF_XCVR_MODE: begin
          rdata_d[XCVR_FIRST] = xcvr_q[0];
          rdata_d[XCVR_SECOND] = xcvr_q[1];
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= {EN_RST, EN_RST};
      base_q[0] <= FIRST_BASE_RST;
      base_q[1] <= SECOND_BASE_RST;
      auto_q <= {AUTO_RST, AUTO_RST};
      oe_q <= {OE_RST, OE_RST};
      xcvr_q <= {XCVR_RST, XCVR_RST};
      cfg_rdata_q <= 8'h00;
      cfg_rvalid_q <= 1'b0;
    end else begin
      en_q <= en_d;
      base_q <= base_d;
      auto_q <= auto_d;
      oe_q <= oe_d;
      xcvr_q <= xcvr_d;
      cfg_rdata_q <= rdata_d;
      cfg_rvalid_q <= rvalid_d;
    end
  end

  // per-port decode and line drivers
  port_cfg_if cfg_link[NUM_PORTS] ();

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    // both the control enable and the mode output enable must be set
    assign cfg_link[p].enable = en_q[p] & oe_q[p];
    assign cfg_link[p].base_sel = base_q[p];
    assign cfg_link[p].auto_dir = auto_q[p];
    assign cfg_link[p].line_std = xcvr_q[p];

    port_line_ctrl u_line (
      .clk(clk),
      .rst(rst),
      .cfg(cfg_link[p]),
      .io_valid(io_valid),
      .io_addr(io_addr),
      .tx_pending(tx_pending[p]),
      .rts_bit(rts_bit[p]),
      .uart_tx(uart_tx[p]),
      .uart_rts(uart_rts[p]),
      .claim_q(claim[p]),
      .tx_q(line_tx_q[p]),
      .tx_oe_n_q(line_tx_oe_n_q[p]),
      .rts_q(line_rts_q[p]),
      .rts_oe_n_q(line_rts_oe_n_q[p])
    );
  end

  assign io_claim_q = claim;

  // forward cycles no port takes; aligned with the registered claims
  always_comb begin
    forward_d = io_valid;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (en_q[p] && oe_q[p] && port_hit(io_addr, base_q[p])) begin
        forward_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_forward_q <= 1'b0;
    end else begin
      io_forward_q <= forward_d;
    end
  end

endmodule : serial_port_config_direction_ctrl

// ---- serial_port_config_direction_ctrl_properties.sv ----
module port_cfg_checker #(
  parameter int NUM_PORTS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_rdata_q,
  input wire logic cfg_rvalid_q,
  // host io
  input wire logic io_valid,
  input wire logic [NUM_PORTS-1:0] io_claim_q,
  input wire logic io_forward_q,
  // line side
  input wire logic [NUM_PORTS-1:0] uart_tx,
  input wire logic [NUM_PORTS-1:0] uart_rts,
  input wire logic [NUM_PORTS-1:0] line_tx_q,
  input wire logic [NUM_PORTS-1:0] line_rts_q,
  input wire logic [NUM_PORTS-1:0] line_tx_oe_n_q,
  input wire logic [NUM_PORTS-1:0] line_rts_oe_n_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd_ctrl; cfg_rd && cfg_addr < 8'h02; endsequence
  sequence rd_mode; cfg_rd && cfg_addr == 8'h02; endsequence
  a_read_answer: assert property (cfg_rd |=> cfg_rvalid_q)
    else $error("read not answered");
  a_ctrl_rsvd_zero: assert property (rd_ctrl |=> cfg_rdata_q[6:4] == 3'h0)
    else $error("control reserved bits read nonzero");
  a_mode_rsvd_zero: assert property (rd_mode |=> cfg_rdata_q[7:6] == 2'h0 && cfg_rdata_q[3:2] == 2'h0)
    else $error("mode reserved bits read nonzero");
  a_one_owner: assert property (io_valid |=> $onehot({io_claim_q, io_forward_q}))
    else $error("io cycle not owned once");
  a_idle_no_claim: assert property (!io_valid |=> io_claim_q == '0 && !io_forward_q)
    else $error("claim without io cycle");
  a_tx_data_follows: assert property (!$past(rst) |-> line_tx_q == $past(uart_tx))
    else $error("line data not one edge behind");
  a_rts_data_follows: assert property (!$past(rst) |-> line_rts_q == $past(uart_rts))
    else $error("line rts not one edge behind");
  a_off_both_released: assert property ((line_rts_oe_n_q & ~line_tx_oe_n_q) == '0)
    else $error("transmitter driven on a disabled port");
  a_reset_enables: assert property ($fell(rst) |-> ##2 line_rts_oe_n_q == '0)
    else $error("ports not enabled after reset");
endmodule : port_cfg_checker

bind serial_port_config_direction_ctrl port_cfg_checker #(.NUM_PORTS(NUM_PORTS)) u_port_cfg_checker (.clk, .rst,
  .cfg_addr, .cfg_rd, .cfg_rdata_q, .cfg_rvalid_q, .io_valid, .io_claim_q, .io_forward_q, .uart_tx, .uart_rts,
  .line_tx_q, .line_rts_q, .line_tx_oe_n_q, .line_rts_oe_n_q);

// ---- serial_port_config_direction_ctrl_tb.sv ----
module serial_port_config_direction_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import port_cfg_pkg::*;
  logic clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, io_valid = 0, cfg_rvalid_q, io_forward_q;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata_q;
  logic [15:0] io_addr = 16'h0000;
  logic [1:0] send_req = 2'h0, rts_req = 2'h0, tx_pending, rts_bit, uart_tx, uart_rts;
  logic [1:0] io_claim_q, line_tx_q, line_tx_oe_n_q, line_rts_q, line_rts_oe_n_q;
  logic [15:0] bases [10] = '{16'h03F8, 16'h02F8, 16'h03E8, 16'h02E8, 16'h0200, 16'h0208, 16'h0220, 16'h0228,
    16'h0238, 16'h0338};
  int n_errors = 0, checked = 0;
  always #2.5 clk = ~clk;
  serial_port_config_direction_ctrl u_serial_port_config_direction_ctrl (.clk, .rst, .cfg_addr, .cfg_wr, .cfg_rd,
    .cfg_wdata, .cfg_rdata_q, .cfg_rvalid_q, .io_valid, .io_addr, .io_claim_q, .io_forward_q, .tx_pending,
    .rts_bit, .uart_tx, .uart_rts, .line_tx_q, .line_tx_oe_n_q, .line_rts_q, .line_rts_oe_n_q);
  serial_engine_model u_serial_engine_model (.clk, .send_req, .rts_req, .tx_pending, .rts_bit, .uart_tx,
    .uart_rts);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    cfg_wr = 1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk) #1;
    cfg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    cfg_rd = 1;
    cfg_addr = a;
    @(posedge clk) #1;
    cfg_rd = 0;
    check({cfg_rvalid_q, cfg_rdata_q}, {1'b1, exp});
  endtask : rd
  // expected is {forward, claim second, claim first}
  task automatic io(input logic [15:0] a, input logic [2:0] exp);
    @(posedge clk) #1;
    io_valid = 1;
    io_addr = a;
    @(posedge clk) #1;
    io_valid = 0;
    check({io_forward_q, io_claim_q}, exp);
  endtask : io
  // expected is {rts_oe_n, tx_oe_n}, config and line inputs need two edges
  task automatic line(input logic [3:0] exp);
    repeat (3) @(posedge clk);
    #1;
    check({line_rts_oe_n_q, line_tx_oe_n_q}, exp);
  endtask : line
  task automatic print_verdict();
    $display("checked %0d, n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #5000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    rd(OFF_FIRST_CTRL, 8'h80);
    rd(OFF_SECOND_CTRL, 8'h81);
    rd(OFF_DIR_MODE, 8'h03);
    rd(OFF_XCVR_MODE, 8'h00);
    $display("test reset_values done");
    wr(OFF_FIRST_CTRL, 8'hFF);
    rd(OFF_FIRST_CTRL, 8'h8F);
    wr(OFF_DIR_MODE, 8'hFF);
    rd(OFF_DIR_MODE, 8'h33);
    wr(8'h7F, 8'hFF);
    rd(8'h7F, 8'h00);
    $display("test reserved_bits done");
    wr(OFF_DIR_MODE, 8'h03);
    wr(OFF_SECOND_CTRL, 8'h01);
    for (int c = 0; c < 10; c++) begin
      wr(OFF_FIRST_CTRL, 8'h80 | 8'(c));
      io(bases[c] + 16'h0007, 3'h1);
      io(bases[c] + 16'h0008, 3'h4);
    end
    io(16'h02F8, 3'h4);
    wr(OFF_FIRST_CTRL, 8'h8A);
    io(16'h03F8, 3'h4);
    wr(OFF_FIRST_CTRL, 8'h80);
    wr(OFF_SECOND_CTRL, 8'h81);
    io(16'h02FF, 3'h2);
    wr(OFF_DIR_MODE, 8'h02);
    io(16'h03F8, 3'h4);
    line(4'h5);
    $display("test decode done");
    wr(OFF_DIR_MODE, 8'h13);
    // auto direction only with both lines in rs-485
    wr(OFF_XCVR_MODE, 8'h03);
    rts_req = 2'h2;
    line(4'h3);
    send_req = 2'h1;
    line(4'h2);
    rts_req = 2'h0;
    line(4'h0);
    wr(OFF_DIR_MODE, 8'h23);
    send_req = 2'h0;
    line(4'h2);
    rts_req = 2'h1;
    line(4'h3);
    $display("test direction done");
    @(posedge clk) #1;
    rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    rd(OFF_DIR_MODE, 8'h03);
    rd(OFF_XCVR_MODE, 8'h00);
    $display("test mid_reset done");
    print_verdict();
  end
endmodule : serial_port_config_direction_ctrl_tb
